// *** design/addr_phase_pkg.sv ***
package addr_phase_pkg;

	localparam int ADDR_HI = 31;
	localparam int ADDR_LO = 3;
	localparam int LINE_LO = 5;
	localparam int MASK_BIT = 20;
	localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
	localparam int LINE_W = ADDR_HI - LINE_LO + 1;
	localparam logic [ADDR_W-1:0] ADDR_RST = 29'h0000000;
	localparam logic [1:0] CDEF_RST = 2'h0;

	typedef enum logic [1:0] {
		CYC_MEM = 2'b00,
		CYC_IO = 2'b01,
		CYC_SPECIAL = 2'b10
	} cycle_kind_t;

	typedef struct packed {
		cycle_kind_t kind;
		logic write;
		logic [ADDR_HI:ADDR_LO] addr;
	} cycle_req_t;

	typedef struct packed {
		logic [ADDR_HI:LINE_LO] addr;
		logic parity_ok;
	} inquire_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} bus_state_t;

endpackage

// *** design/line_parity.sv ***
`timescale 1ns/100ps
module line_parity
	import addr_phase_pkg::*;
#(
	parameter int WIDTH = LINE_W
) (
	input wire logic [WIDTH-1:0] bits_i,
	output logic even_bit_o
);
	// even parity: the bit that makes the total count of ones even
	assign even_bit_o = ^bits_i;
endmodule

// *** design/addr_phase_bus.sv ***
`timescale 1ns/100ps
// What this block does
// - while bit20 mask asserted, clear address bit 20 before lookup and bus cycle, except for special cycles
// - drive cycle address, or cycle definition data for special cycles
// - lines 31..5 two-way, 4..3 output only; inquire samples 31..5
// - start strobe low for the first clock of each bus cycle
// - address and cycle definition valid on the strobe's edge
// - strobe copy mirrors the start strobe exactly
// - float address 31..3 and parity once float request has passed the two-flop synchroniser
// - other outputs stay driven while float request is active
// - parity bit makes ones over itself and lines 31..5 even
// - lines 4 and 3 take no part in parity
module addr_phase_bus
	import addr_phase_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic req_valid_i,
	input wire cycle_req_t req_i,
	output logic req_ready_o,
	output logic [ADDR_HI:ADDR_LO] lookup_addr_o,
	input wire logic cycle_done_i,
	input wire logic addr_bit20_mask_n_i,
	input wire logic addr_float_request_i,
	input wire logic [ADDR_HI:LINE_LO] addr_in_i,
	output logic [ADDR_HI:ADDR_LO] addr_out_o,
	output logic addr_oe_n_o,
	input wire logic addr_parity_bit_in_i,
	output logic addr_parity_bit_out_o,
	output logic addr_parity_bit_oe_n_o,
	output logic cycle_start_strobe_n_o,
	output logic cycle_start_strobe_copy_n_o,
	output logic [1:0] cycle_kind_o,
	output logic cycle_write_o,
	output logic inquire_valid_o,
	output inquire_t inquire_o
);
	logic mask_s1_q, mask_s2_q;
	logic float_s1_q, float_s2_q;
	logic [ADDR_HI:LINE_LO] ain_s1_q, ain_s2_q;
	logic par_s1_q, par_s2_q;
	logic float_prev_q;
	bus_state_t state_q;
	logic [ADDR_HI:ADDR_LO] masked_addr;
	logic [ADDR_HI:ADDR_LO] addr_q;
	logic [1:0] kind_q;
	logic write_q;
	logic strobe_q;
	logic par_out_q;
	logic out_par;
	logic in_par;
	logic start;

	// mask, float request, address and parity pins pass two flops before use; cycle_done_i is used directly
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			mask_s1_q <= 1'b0;
			mask_s2_q <= 1'b0;
			float_s1_q <= 1'b0;
			float_s2_q <= 1'b0;
			ain_s1_q <= '0;
			ain_s2_q <= '0;
			par_s1_q <= 1'b0;
			par_s2_q <= 1'b0;
		end else begin
			mask_s1_q <= ~addr_bit20_mask_n_i;
			mask_s2_q <= mask_s1_q;
			float_s1_q <= addr_float_request_i;
			float_s2_q <= float_s1_q;
			ain_s1_q <= addr_in_i;
			ain_s2_q <= ain_s1_q;
			par_s1_q <= addr_parity_bit_in_i;
			par_s2_q <= par_s1_q;
		end
	end

	// special cycles carry definition data, never masked
	always_comb begin
		masked_addr = req_i.addr;
		if (mask_s2_q && req_i.kind != CYC_SPECIAL) begin
			masked_addr[MASK_BIT] = 1'b0;
		end
	end
	assign lookup_addr_o = masked_addr;

	// no new cycle while the address lines are handed to the system
	assign req_ready_o = (state_q == ST_IDLE) && !float_s2_q;
	assign start = req_valid_i && req_ready_o;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					if (cycle_done_i) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// address, definition and strobe all load on the same edge
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			addr_q <= ADDR_RST;
			kind_q <= CDEF_RST;
			write_q <= 1'b0;
			strobe_q <= 1'b0;
			par_out_q <= ^ADDR_RST[ADDR_W-1:LINE_LO-ADDR_LO];
		end else begin
			strobe_q <= start;
			if (start) begin
				addr_q <= masked_addr;
				kind_q <= req_i.kind;
				write_q <= req_i.write;
				par_out_q <= out_par;
			end
		end
	end

	assign cycle_start_strobe_n_o = ~strobe_q;
	assign cycle_start_strobe_copy_n_o = ~strobe_q;
	assign cycle_kind_o = kind_q;
	assign cycle_write_o = write_q;
	assign addr_out_o = addr_q;

	// parity worked out ahead so it loads with the address, not a gate level later
	line_parity #(.WIDTH(LINE_W)) u_out_par (
		.bits_i(masked_addr[ADDR_HI:LINE_LO]),
		.even_bit_o(out_par)
	);
	line_parity #(.WIDTH(LINE_W)) u_in_par (
		.bits_i(ain_s2_q),
		.even_bit_o(in_par)
	);
	assign addr_parity_bit_out_o = par_out_q;

	// float follows the synchronised request directly; lines 4..3 float too
	assign addr_oe_n_o = float_s2_q;
	assign addr_parity_bit_oe_n_o = float_s2_q;

	// capture one inquire address at the start of each float window
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			float_prev_q <= 1'b0;
			inquire_valid_o <= 1'b0;
			inquire_o <= '0;
		end else begin
			float_prev_q <= float_s2_q;
			inquire_valid_o <= float_s2_q && !float_prev_q;
			if (float_s2_q && !float_prev_q) begin
				inquire_o.addr <= ain_s2_q;
				inquire_o.parity_ok <= (in_par == par_s2_q);
			end
		end
	end

	property p_copy_match;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		cycle_start_strobe_copy_n_o == cycle_start_strobe_n_o;
	endproperty
	a_copy_match: assert property (p_copy_match) else $error("copy differs");

	property p_strobe_one;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!cycle_start_strobe_n_o |=> cycle_start_strobe_n_o;
	endproperty
	a_strobe_one: assert property (p_strobe_one) else $error("strobe too long");

	property p_start_strobe;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		start |=> !cycle_start_strobe_n_o && addr_out_o == $past(masked_addr);
	endproperty
	a_start_strobe: assert property (p_start_strobe) else $error("addr not with strobe");

	property p_mask20;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		start && mask_s2_q && req_i.kind != CYC_SPECIAL |=> addr_out_o[MASK_BIT] == 1'b0;
	endproperty
	a_mask20: assert property (p_mask20) else $error("bit 20 not cleared");

	property p_addr_kept;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		start && (req_i.kind == CYC_SPECIAL || !mask_s2_q) |=> addr_out_o == $past(req_i.addr);
	endproperty
	a_addr_kept: assert property (p_addr_kept) else $error("address altered");

	// holds only where the pin moves on the clock edge, as the system model drives it
	property p_float;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$past(rst_n_i, 2) |-> addr_oe_n_o == $past(addr_float_request_i, 2)
			&& addr_parity_bit_oe_n_o == addr_oe_n_o;
	endproperty
	a_float: assert property (p_float) else $error("lines not floated");

	property p_parity;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		^{addr_parity_bit_out_o, addr_out_o[ADDR_HI:LINE_LO]} == 1'b0;
	endproperty
	a_parity: assert property (p_parity) else $error("parity not even");

	property p_no_start_float;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		float_s2_q |-> !start ##1 cycle_start_strobe_n_o;
	endproperty
	a_no_start_float: assert property (p_no_start_float) else $error("cycle under float");

	property p_inq_capture;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(float_s2_q) |=> inquire_valid_o && inquire_o.addr == $past(ain_s2_q);
	endproperty
	a_inq_capture: assert property (p_inq_capture) else $error("inquire missed");

	property p_inq_parity;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(float_s2_q) |=> inquire_o.parity_ok == ~^{$past(par_s2_q), $past(ain_s2_q)};
	endproperty
	a_inq_parity: assert property (p_inq_parity) else $error("inquire parity wrong");

	property p_inq_pulse;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		inquire_valid_o |=> !inquire_valid_o;
	endproperty
	a_inq_pulse: assert property (p_inq_pulse) else $error("inquire pulse too long");

	// definition outputs change only with a new strobe
	property p_defs_hold;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!start |=> $stable(addr_out_o) && $stable(cycle_kind_o) && $stable(cycle_write_o)
			&& $stable(addr_parity_bit_out_o);
	endproperty
	a_defs_hold: assert property (p_defs_hold) else $error("definition moved");
endmodule

// *** dv/chipset_model.sv ***
`timescale 1ns/100ps
module chipset_model
	import addr_phase_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic inq_go_i,
	input wire logic [ADDR_HI:LINE_LO] inq_addr_i,
	input wire logic inq_bad_par_i,
	output logic addr_float_request_o,
	output logic [ADDR_HI:LINE_LO] addr_in_o,
	output logic addr_parity_bit_in_o
);
	logic float_q = 1'b0;
	logic [ADDR_HI:LINE_LO] lines_q = '0;
	logic par_q = 1'b0;
	// released lines toggle so a stale value is never mistaken for a driven one
	// a bad parity request flips the bit, to prove the device's check
	always @(posedge sys_clk_i) begin
		float_q <= inq_go_i;
		lines_q <= inq_go_i ? inq_addr_i : ~lines_q;
		par_q <= inq_go_i ? (^inq_addr_i ^ inq_bad_par_i) : ~par_q;
	end
	assign addr_float_request_o = float_q;
	assign addr_in_o = lines_q;
	assign addr_parity_bit_in_o = par_q;
endmodule

// *** dv/addr_phase_bus_tb_top.sv ***
`timescale 1ns/100ps
module addr_phase_bus_tb_top
	import addr_phase_pkg::*;
;
	logic clk = 0, rst_n = 0, valid = 0, done = 0, mask_n = 1, go = 0, bad = 0;
	logic fl, pin, rdy, oe_n, pout, poe_n, stb, stb2, wr, iv;
	logic [ADDR_HI:LINE_LO] ain, ia;
	logic [ADDR_HI:ADDR_LO] aout, look;
	logic [1:0] kd;
	cycle_req_t rq = '0;
	inquire_t inq;
	int miscompares = 0, tests_run = 0;
	integer seed = 32'h159D;
	logic [31:0] r;
	initial forever #2.5 clk = ~clk;
	chipset_model peer (.sys_clk_i(clk), .inq_go_i(go), .inq_addr_i(ia), .inq_bad_par_i(bad),
		.addr_float_request_o(fl), .addr_in_o(ain), .addr_parity_bit_in_o(pin));
	addr_phase_bus dut (.sys_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(valid), .req_i(rq),
		.req_ready_o(rdy), .lookup_addr_o(look), .cycle_done_i(done),
		.addr_bit20_mask_n_i(mask_n), .addr_float_request_i(fl), .addr_in_i(ain),
		.addr_out_o(aout), .addr_oe_n_o(oe_n), .addr_parity_bit_in_i(pin),
		.addr_parity_bit_out_o(pout), .addr_parity_bit_oe_n_o(poe_n),
		.cycle_start_strobe_n_o(stb), .cycle_start_strobe_copy_n_o(stb2),
		.cycle_kind_o(kd), .cycle_write_o(wr), .inquire_valid_o(iv), .inquire_o(inq));
	task automatic check(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function automatic logic [ADDR_HI:ADDR_LO] exp_addr(cycle_req_t q, logic m_n);
		exp_addr = q.addr;
		if (!m_n && q.kind != CYC_SPECIAL)
			exp_addr[MASK_BIT] = 1'b0;
	endfunction
	task automatic run_cycle(input cycle_kind_t k);
		int n;
		r = $random(seed);
		rq = '{kind: k, write: r[0], addr: ADDR_W'($random(seed)) | 29'h0020000};
		valid = 1;
		// a refused request must not start a cycle at the next edge
		for (n = 0; n < 20 && rdy !== 1'b1; n++) begin
			@(negedge clk);
			check("strobe held", stb, 1'b1);
		end
		@(negedge clk);
		check("lookup", look, exp_addr(rq, mask_n));
		valid = 0;
		check("strobe", stb, 1'b0);
		check("strobe copy", stb2, 1'b0);
		check("addr", aout, exp_addr(rq, mask_n));
		check("kind", kd, rq.kind);
		check("write", wr, rq.write);
		check("parity", pout ^ (^aout[ADDR_HI:LINE_LO]), 1'b0);
		@(negedge clk);
		check("strobe end", {stb, stb2}, 2'b11);
		done = 1;
		@(negedge clk);
		done = 0;
		$display("cycle kind %0d done", k);
	endtask
	initial begin
		ia = '0;
		repeat (5) @(negedge clk);
		rst_n = 1;
		repeat (12) run_cycle(cycle_kind_t'(($unsigned($random(seed)) % 3)));
		mask_n = 0;
		repeat (3) @(negedge clk);
		for (int k = 0; k < 3; k++)
			run_cycle(cycle_kind_t'(k));
		mask_n = 1;
		for (int t = 0; t < 4; t++) begin
			ia = LINE_W'($random(seed));
			bad = t[0];
			go = 1;
			for (int n = 0; n < 8 && iv !== 1'b1; n++)
				@(negedge clk);
			check("inquire addr", inq.addr, ia);
			check("inquire parity", inq.parity_ok, !bad);
			check("float", {oe_n, poe_n, rdy}, 3'b110);
			check("strobe held", {stb, stb2}, 2'b11);
			go = 0;
			bad = 0;
			@(negedge clk);
			check("inquire pulse", iv, 1'b0);
			// request raised while the lines are still floated
			run_cycle(CYC_MEM);
			check("float end", {oe_n, poe_n}, 2'b00);
			$display("inquire %0d done", t);
		end
		wrap_up();
	end
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		wrap_up();
	end
endmodule
